//--- dv/ics_host_model.sv
/* Bus host model: drives SCL, pulls SDA low open-drain.
 Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
module ics_host_model #(
  parameter integer QTR = 8
) (
  input  wire clk_in,
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wait_q;
    repeat (QTR) @(posedge clk_in);
  endtask
  task automatic start_c;
    sda_low_out <= 1'b0;
    wait_q;
    scl_out <= 1'b1;
    wait_q;
    sda_low_out <= 1'b1;
    wait_q;
    scl_out <= 1'b0;
    wait_q;
  endtask
  task automatic stop_c;
    sda_low_out <= 1'b1;
    wait_q;
    scl_out <= 1'b1;
    wait_q;
    sda_low_out <= 1'b0;
    wait_q;
  endtask
  task automatic bit_x(input b, output r);
    sda_low_out <= ~b;
    wait_q;
    scl_out <= 1'b1;
    wait_q;
    r = sda_in;
    wait_q;
    scl_out <= 1'b0;
    wait_q;
  endtask
  task automatic xfer(input [7:0] d, input last, output [7:0] q, output ack_n);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
      bit_x(d[i], q[i]);
    bit_x(last, ack_n);
  endtask
endmodule

//--- dv/ics_i2c_adc_cmd_seq_tb_top.sv
/* Testbench of the command sequencer with the bus host model.
 Assumes pull-ups on SDA and on the ready pin. */
`timescale 1ns/1ps
module ics_i2c_adc_cmd_seq_tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [1:0]  strap_lo = 2'h1;
  reg  [1:0]  strap_hi = 2'h2;
  reg  [15:0] sample = 16'h0000;
  reg         valid = 1'b0;
  wire        scl, host_low, sda_oe_n, sda_dev, rdy_n, rdy_oe_n, conv, pdn, shorted;
  wire [7:0]  cfg;
  wire [15:0] fs;
  wire [6:0]  taddr;
  wire [6:0]  tgt = {3'b100, strap_hi, strap_lo};
  wire        sda = ~(host_low | (~sda_oe_n & ~sda_dev));
  wire        rdy_pin = rdy_oe_n | rdy_n;
  integer     mismatches = 0;
  integer     checks_done = 0;
  integer     i;
  reg  [15:0] v;
  reg         ack_n;
  integer     ofs;
  always #2.5 clk = ~clk;
  ics_i2c_adc_cmd_seq #(.EXT_REF_MV(16'd3000)) i_ics_i2c_adc_cmd_seq (
    .CORE_CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda), .ADDR_STRAP_PIN_LO_IN(strap_lo),
    .ADDR_STRAP_PIN_HI_IN(strap_hi), .SAMPLE_IN(sample), .SAMPLE_VALID_IN(valid), .SDA_OUT(sda_dev),
    .SDA_OE_N_OUT(sda_oe_n), .RESULT_READY_N_OUT(rdy_n), .RESULT_READY_N_OE_N_OUT(rdy_oe_n),
    .CONVERTING_OUT(conv), .POWERED_DOWN_OUT(pdn), .CONFIG_OUT(cfg), .INPUTS_SHORTED_OUT(shorted),
    .FULL_SCALE_MV_OUT(fs), .TARGET_ADDR_OUT(taddr));
  ics_host_model i_ics_host_model (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  task automatic chk(input string what, input [15:0] exp, input [15:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Write transaction; a foreign address must be left unanswered
  task automatic send(input [6:0] a, input [7:0] c, input more, input [7:0] d);
    reg [7:0] q;
    i_ics_host_model.start_c;
    i_ics_host_model.xfer({a, 1'b0}, 1'b1, q, ack_n);
    if (!ack_n) i_ics_host_model.xfer(c, 1'b1, q, ack_n);
    if (more && !ack_n) i_ics_host_model.xfer(d, 1'b1, q, ack_n);
    i_ics_host_model.stop_c;
    chk("ack", a != tgt, ack_n);
  endtask
  task automatic rd(input two, output [15:0] r);
    reg [7:0] q;
    i_ics_host_model.start_c;
    i_ics_host_model.xfer({tgt, 1'b1}, 1'b1, q, ack_n);
    i_ics_host_model.xfer(8'hff, ~two, r[15:8], ack_n);
    r[7:0] = 8'h00;
    if (two) i_ics_host_model.xfer(8'hff, 1'b1, r[7:0], ack_n);
    i_ics_host_model.stop_c;
  endtask
  task automatic smp(input [15:0] s);
    @(posedge clk);
    sample <= s;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    #400000;
    mismatches = mismatches + 1;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk("config", 16'h0000, cfg);
    chk("address", tgt, taddr);
    chk("ready", 16'h0001, rdy_pin);
    send(tgt, 8'h06, 0, 0);
    send(tgt, 8'h40, 1, 8'h12);
    chk("config", 16'h0012, cfg);
    chk("full scale", 16'd512, fs);
    send(tgt, 8'h20, 0, 0);
    rd(0, v);
    chk("readback", 16'h1200, v);
    send(tgt, 8'h44, 1, 8'hff);
    chk("config", 16'h0012, cfg);
    $display("test config done");
    send(tgt, 8'h08, 0, 0);
    for (i = 0; i < 2; i = i + 1) begin
      smp(16'h8a5c ^ {16{i[0]}});
      chk("ready", 16'h0000, rdy_pin);
      chk("converting", 16'h0001, conv);
      send(tgt, 8'h24, 0, 0);
      rd(0, v);
      chk("status", 16'h8000, v);
      send(tgt, 8'h10, 0, 0);
      chk("ready", 16'h0001, rdy_pin);
      rd(1, v);
      chk("result", 16'h8a5c ^ {16{i[0]}}, v);
    end
    $display("test continuous done");
    send(tgt, 8'h40, 1, 8'he2);
    chk("shorted", 16'h0001, shorted);
    // offset is the mean of shorted readings, then subtracted
    ofs = 0;
    for (i = 0; i < 2; i = i + 1) begin
      smp(i[0] ? 16'hfffc : 16'hfffe);
      send(tgt, 8'h10, 0, 0);
      rd(1, v);
      ofs = ofs + $signed(v);
    end
    chk("offset", 16'hfffd, ofs / 2);
    chk("corrected", 16'hffff, v - ofs / 2);
    send(tgt, 8'h02, 0, 0);
    chk("converting", 16'h0000, conv);
    chk("asleep", 16'h0001, pdn);
    smp(16'h0055);
    chk("ready", 16'h0001, rdy_pin);
    send(tgt, 8'h06, 0, 0);
    chk("config", 16'h0000, cfg);
    chk("asleep", 16'h0000, pdn);
    $display("test sleep done");
    send(tgt, 8'h40, 1, 8'h01);
    chk("full scale", 16'd3000, fs);
    send(tgt, 8'h08, 0, 0);
    smp(16'h0007);
    chk("converting", 16'h0000, conv);
    send(tgt ^ 7'h01, 8'h06, 0, 0);
    chk("config", 16'h0001, cfg);
    rst <= 1'b1;
    strap_lo <= 2'h3;
    strap_hi <= 2'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk("address", tgt, taddr);
    send(tgt, 8'h06, 0, 0);
    $display("test address done");
    test_done;
  end
endmodule

//--- dv/ics_seq_monitor.sv
/* Port checker for the converter command sequencer.
 Assumes straps change only while reset is held. */
`timescale 1ns/1ps
module ics_seq_monitor #(
  parameter [15:0] EXT_REF_MV = 16'd2500
) (
  input wire        CORE_CLK_IN,
  input wire        RST_IN,
  input wire        SCL_IN,
  input wire [1:0]  ADDR_STRAP_PIN_LO_IN,
  input wire [1:0]  ADDR_STRAP_PIN_HI_IN,
  input wire        SAMPLE_VALID_IN,
  input wire        SDA_OE_N_OUT,
  input wire        RESULT_READY_N_OE_N_OUT,
  input wire        CONVERTING_OUT,
  input wire        POWERED_DOWN_OUT,
  input wire [7:0]  CONFIG_OUT,
  input wire        INPUTS_SHORTED_OUT,
  input wire [15:0] FULL_SCALE_MV_OUT,
  input wire [6:0]  TARGET_ADDR_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  wire take = SAMPLE_VALID_IN && CONVERTING_OUT;
  sequence s_straps_held;
    // Sampled reset keeps the release edge, before the latch, out of the window
    (!RST_IN && $stable(ADDR_STRAP_PIN_LO_IN) && $stable(ADDR_STRAP_PIN_HI_IN)) [*4];
  endsequence
  property p_addr;
    s_straps_held |-> TARGET_ADDR_OUT == {3'b100, ADDR_STRAP_PIN_HI_IN, ADDR_STRAP_PIN_LO_IN};
  endproperty
  a_addr: assert property (p_addr) else $error("address not from straps");
  property p_fs;
    FULL_SCALE_MV_OUT == (($past(CONFIG_OUT[0]) ? EXT_REF_MV : 16'd2048) >> ($past(CONFIG_OUT[4]) ? 2 : 0));
  endproperty
  a_fs: assert property (p_fs) else $error("full scale wrong");
  property p_short;
    INPUTS_SHORTED_OUT == ($past(CONFIG_OUT[7:5]) == 3'b111);
  endproperty
  a_short: assert property (p_short) else $error("short flag wrong");
  property p_rdy_set;
    take |=> !RESULT_READY_N_OE_N_OUT;
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("ready pin not pulled");
  property p_rdy_cause;
    $fell(RESULT_READY_N_OE_N_OUT) |-> $past(take);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready pin without result");
  property p_single;
    take && !CONFIG_OUT[1] |=> !CONVERTING_OUT;
  endproperty
  a_single: assert property (p_single) else $error("single shot kept running");
  property p_cont;
    take && CONFIG_OUT[1] |=> CONVERTING_OUT [*2];
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode stopped");
  property p_sleep;
    $rose(POWERED_DOWN_OUT) |-> !CONVERTING_OUT;
  endproperty
  a_sleep: assert property (p_sleep) else $error("converting while asleep");
  property p_sda;
    $changed(SDA_OE_N_OUT) |-> !SCL_IN && !$past(SCL_IN, 2);
  endproperty
  a_sda: assert property (p_sda) else $error("data line moved with clock high");
endmodule
bind ics_i2c_adc_cmd_seq ics_seq_monitor #(.EXT_REF_MV(EXT_REF_MV)) i_ics_seq_monitor (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .SCL_IN(SCL_IN),
  .ADDR_STRAP_PIN_LO_IN(ADDR_STRAP_PIN_LO_IN), .ADDR_STRAP_PIN_HI_IN(ADDR_STRAP_PIN_HI_IN),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .SDA_OE_N_OUT(SDA_OE_N_OUT),
  .RESULT_READY_N_OE_N_OUT(RESULT_READY_N_OE_N_OUT), .CONVERTING_OUT(CONVERTING_OUT),
  .POWERED_DOWN_OUT(POWERED_DOWN_OUT), .CONFIG_OUT(CONFIG_OUT), .INPUTS_SHORTED_OUT(INPUTS_SHORTED_OUT),
  .FULL_SCALE_MV_OUT(FULL_SCALE_MV_OUT), .TARGET_ADDR_OUT(TARGET_ADDR_OUT));

//--- hw/ics_consts.vh
/*
 Constants for the I2C converter command sequencer: command codes, configuration
 field positions, reset values and address layout. Definitions only.
*/
`ifndef ICS_CONSTS_VH
`define ICS_CONSTS_VH

// Command bytes
`define ICS_CMD_RESET        8'h06
`define ICS_CMD_START        8'h08
`define ICS_CMD_SLEEP        8'h02
`define ICS_CMD_READ_DATA    8'h10
// Upper nibble of register read and write commands, register index in bits 3:2
`define ICS_CMD_REGRD_NIB    4'h2
`define ICS_CMD_REGWR_NIB    4'h4
`define ICS_REG_IDX_CFG      2'h0
`define ICS_REG_IDX_STATUS   2'h1

// Configuration register fields
`define ICS_CFG_RESET        8'h00
`define ICS_CFG_SEL_HI       7
`define ICS_CFG_SEL_LO       5
`define ICS_CFG_GAIN         4
`define ICS_CFG_RATE_HI      3
`define ICS_CFG_RATE_LO      2
`define ICS_CFG_MODE         1
`define ICS_CFG_VREF         0
`define ICS_SEL_SHORTED      3'b111

// Status register: ready flag position
`define ICS_STAT_READY       7

// Target address: fixed upper bits, then two 2-bit strap codes
`define ICS_ADDR_BASE        3'b100

// Internal reference in millivolts
`define ICS_INT_REF_MV       16'd2048

`endif

//--- hw/ics_i2c_adc_cmd_seq.v
/*
 I2C target and command interpreter of a 16-bit converter: address from two
 four-level straps, command decode, configuration and status registers, result
 hand-out and open-drain ready output.
 Assumes the converter core hands in SAMPLE_IN with a one-cycle SAMPLE_VALID_IN
 on CORE_CLK_IN while CONVERTING_OUT is high; SCL and SDA come from the bus.
*/
`timescale 1ns/1ps
`include "ics_consts.vh"

module ics_i2c_adc_cmd_seq #(
  parameter [15:0] EXT_REF_MV = 16'd2500
) (
  input  wire        CORE_CLK_IN,
  input  wire        RST_IN,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  input  wire [1:0]  ADDR_STRAP_PIN_LO_IN,
  input  wire [1:0]  ADDR_STRAP_PIN_HI_IN,
  input  wire [15:0] SAMPLE_IN,
  input  wire        SAMPLE_VALID_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE_N_OUT,
  output wire        RESULT_READY_N_OUT,
  output wire        RESULT_READY_N_OE_N_OUT,
  output wire        CONVERTING_OUT,
  output wire        POWERED_DOWN_OUT,
  output wire [7:0]  CONFIG_OUT,
  output wire        INPUTS_SHORTED_OUT,
  output wire [15:0] FULL_SCALE_MV_OUT,
  output wire [6:0]  TARGET_ADDR_OUT
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_RX   = 2'd1;
  localparam [1:0] ST_TX   = 2'd2;
  localparam [1:0] ST_HOLD = 2'd3;

  reg        scl_s1;
  reg        scl_s2;
  reg        scl_d;
  reg        sda_s1;
  reg        sda_s2;
  reg        sda_d;
  reg [1:0]  strap_lo_s1;
  reg [1:0]  strap_lo_s2;
  reg [1:0]  strap_hi_s1;
  reg [1:0]  strap_hi_s2;
  reg [1:0]  strap_wait;
  reg [6:0]  target_addr;
  reg [1:0]  state;
  reg [3:0]  bitcnt;
  reg        ack_phase;
  reg        addr_phase;
  reg        load_pending;
  reg [1:0]  load_idx;
  reg [7:0]  rx_shift;
  reg [7:0]  tx_shift;
  reg [15:0] tx_buf;
  reg        tx_second;
  reg        sda_oe_n;
  reg [7:0]  config_reg;
  reg [15:0] result;
  reg        ready_flag;
  reg        ready_oe_n;
  reg        converting;
  reg        powered_down;
  reg        shorted;
  reg [15:0] full_scale;

  wire scl_rise   = scl_s2 & ~scl_d;
  wire scl_fall   = ~scl_s2 & scl_d;
  wire bus_start  = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop   = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire new_sample = SAMPLE_VALID_IN & converting;
  wire [7:0] status_byte = {ready_flag, 7'h00};
  wire [15:0] ref_mv = config_reg[`ICS_CFG_VREF] ? EXT_REF_MV : `ICS_INT_REF_MV;

  // no clock drive
  // SCL is an input only; the data line is open-drain, pulled low or released.
  assign SDA_OUT                 = 1'b0;
  assign SDA_OE_N_OUT            = sda_oe_n;
  assign RESULT_READY_N_OUT      = 1'b0;
  assign RESULT_READY_N_OE_N_OUT = ready_oe_n;
  assign CONVERTING_OUT          = converting;
  assign POWERED_DOWN_OUT        = powered_down;
  assign CONFIG_OUT              = config_reg;
  assign INPUTS_SHORTED_OUT      = shorted;
  assign FULL_SCALE_MV_OUT       = full_scale;
  assign TARGET_ADDR_OUT         = target_addr;

  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_s1       <= 1'b1;
      scl_s2       <= 1'b1;
      scl_d        <= 1'b1;
      sda_s1       <= 1'b1;
      sda_s2       <= 1'b1;
      sda_d        <= 1'b1;
      strap_lo_s1  <= 2'h0;
      strap_lo_s2  <= 2'h0;
      strap_hi_s1  <= 2'h0;
      strap_hi_s2  <= 2'h0;
      strap_wait   <= 2'h0;
      target_addr  <= 7'h00;
      state        <= ST_IDLE;
      bitcnt       <= 4'h0;
      ack_phase    <= 1'b0;
      addr_phase   <= 1'b0;
      load_pending <= 1'b0;
      load_idx     <= 2'h0;
      rx_shift     <= 8'h00;
      tx_shift     <= 8'h00;
      tx_buf       <= 16'h0000;
      tx_second    <= 1'b0;
      sda_oe_n     <= 1'b1;
      config_reg   <= `ICS_CFG_RESET;
      result       <= 16'h0000;
      ready_flag   <= 1'b0;
      ready_oe_n   <= 1'b1;
      converting   <= 1'b0;
      powered_down <= 1'b0;
      shorted      <= 1'b0;
      full_scale   <= `ICS_INT_REF_MV;
    end else begin
      scl_s1      <= SCL_IN;
      scl_s2      <= scl_s1;
      scl_d       <= scl_s2;
      sda_s1      <= SDA_IN;
      sda_s2      <= sda_s1;
      sda_d       <= sda_s2;
      strap_lo_s1 <= ADDR_STRAP_PIN_LO_IN;
      strap_lo_s2 <= strap_lo_s1;
      strap_hi_s1 <= ADDR_STRAP_PIN_HI_IN;
      strap_hi_s2 <= strap_hi_s1;

      // strap address latch
      // Straps are caught once the synchroniser has filled, never while in reset.
      if (strap_wait != 2'h3) begin
        strap_wait <= strap_wait + 2'h1;
        if (strap_wait == 2'h2) begin
          target_addr <= {`ICS_ADDR_BASE, strap_hi_s2, strap_lo_s2};
        end
      end

      shorted <= (config_reg[`ICS_CFG_SEL_HI:`ICS_CFG_SEL_LO] == `ICS_SEL_SHORTED);
      full_scale <= config_reg[`ICS_CFG_GAIN] ? {2'b00, ref_mv[15:2]} : ref_mv;

      if (new_sample) begin
        result     <= SAMPLE_IN;
        ready_flag <= 1'b1;
        ready_oe_n <= 1'b0;
        if (!config_reg[`ICS_CFG_MODE]) begin
          converting <= 1'b0;
        end
      end

      if (bus_start) begin
        state      <= ST_RX;
        addr_phase <= 1'b1;
        bitcnt     <= 4'h0;
        ack_phase  <= 1'b0;
        sda_oe_n   <= 1'b1;
      end else if (bus_stop) begin
        state        <= ST_IDLE;
        ack_phase    <= 1'b0;
        load_pending <= 1'b0;
        sda_oe_n     <= 1'b1;
      end else if (scl_rise) begin
        if (state == ST_RX && bitcnt != 4'h8) begin
          rx_shift <= {rx_shift[6:0], sda_s2};
          bitcnt   <= bitcnt + 4'h1;
        end else if (state == ST_TX && !ack_phase && bitcnt != 4'h8) begin
          bitcnt <= bitcnt + 4'h1;
        end else if (state == ST_TX && ack_phase && sda_s2) begin
          // Host refused the byte: stay off the bus until stop or restart
          state <= ST_HOLD;
        end
      end else if (scl_fall) begin
        if (state == ST_RX && bitcnt == 4'h8 && !ack_phase) begin
          ack_phase <= 1'b1;
          if (addr_phase && rx_shift[7:1] != target_addr) begin
            state <= ST_HOLD;
          end else begin
            sda_oe_n <= 1'b0;
          end
        end else if (state == ST_RX && ack_phase) begin
          ack_phase <= 1'b0;
          bitcnt    <= 4'h0;
          sda_oe_n  <= 1'b1;
          if (addr_phase) begin
            addr_phase <= 1'b0;
            if (rx_shift[0]) begin
              state     <= ST_TX;
              tx_shift  <= tx_buf[15:8];
              tx_second <= 1'b1;
              sda_oe_n  <= tx_buf[15];
            end
          end else if (load_pending) begin
            load_pending <= 1'b0;
            if (load_idx == `ICS_REG_IDX_CFG) begin
              config_reg <= rx_shift;
            end
          end else if (rx_shift == `ICS_CMD_RESET) begin
            config_reg   <= `ICS_CFG_RESET;
            result       <= 16'h0000;
            ready_flag   <= 1'b0;
            ready_oe_n   <= 1'b1;
            converting   <= 1'b0;
            powered_down <= 1'b0;
            tx_buf       <= 16'h0000;
          end else if (rx_shift == `ICS_CMD_START) begin
            converting   <= 1'b1;
            powered_down <= 1'b0;
          end else if (rx_shift == `ICS_CMD_SLEEP) begin
            converting   <= 1'b0;
            powered_down <= 1'b1;
          end else if (rx_shift == `ICS_CMD_READ_DATA) begin
            // flag cleared unless a result lands now
            tx_buf     <= result;
            ready_flag <= new_sample;
            ready_oe_n <= ~new_sample;
          end else if (rx_shift[7:4] == `ICS_CMD_REGRD_NIB) begin
            tx_buf <= {(rx_shift[3:2] == `ICS_REG_IDX_STATUS) ? status_byte :
                       (rx_shift[3:2] == `ICS_REG_IDX_CFG) ? config_reg : 8'h00, 8'h00};
          end else if (rx_shift[7:4] == `ICS_CMD_REGWR_NIB) begin
            load_pending <= 1'b1;
            load_idx     <= rx_shift[3:2];
          end
        end else if (state == ST_TX && !ack_phase && bitcnt == 4'h8) begin
          // Release the line so the host can answer
          sda_oe_n  <= 1'b1;
          ack_phase <= 1'b1;
        end else if (state == ST_TX && !ack_phase && bitcnt != 4'h0) begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          sda_oe_n <= tx_shift[6];
        end else if (state == ST_TX && ack_phase) begin
          ack_phase <= 1'b0;
          bitcnt    <= 4'h0;
          tx_second <= 1'b0;
          tx_shift  <= tx_second ? tx_buf[7:0] : 8'h00;
          sda_oe_n  <= tx_second ? tx_buf[7] : 1'b1;
        end
      end
    end
  end

endmodule
